// ### logic/slp_consts.svh
`ifndef SLP_CONSTS_SVH
`define SLP_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses on the serial control port
// ----------------------------------------------------------------
`define SLP_A_SOFT_RST 15'h0000
`define SLP_A_DP_RST 15'h0001
`define SLP_A_PWR_MODE 15'h0002
`define SLP_A_CHAN_BW 15'h0200
`define SLP_A_DECIM 15'h0201
`define SLP_A_OUT_FMT 15'h0561
`define SLP_A_LANE_RATE 15'h056E
`define SLP_A_PLL_STAT 15'h056F
`define SLP_A_LINK_MODE 15'h0570
`define SLP_A_LINK_CTL 15'h0571
`define SLP_A_WORD_FMT 15'h058B
`define SLP_A_SUBCLASS 15'h058F
`define SLP_A_DEEMPH_LO 15'h05C4
`define SLP_A_DEEMPH_HI 15'h05CB
`define SLP_A_LANES 15'h0600
`define SLP_A_CONVS 15'h0601
`define SLP_A_PLL_CAL 15'h1222
`define SLP_A_STARTUP 15'h1228
`define SLP_A_LOL_CLR 15'h1262

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SLP_RST_ZERO 8'h00
`define SLP_RST_DECIM 8'h01
`define SLP_RST_LANE_RATE 8'h30
`define SLP_RST_LINK_CTL 8'h14
`define SLP_RST_STARTUP 8'h0F
`define SLP_RST_LANES 8'h08
`define SLP_RST_CONVS 8'h02

// ----------------------------------------------------------------
// Command values and field positions
// ----------------------------------------------------------------
`define SLP_V_SOFT_RST 8'h81
`define SLP_V_DP_RST 8'h02
`define SLP_V_LINK_DOWN 8'h15
`define SLP_V_LINK_UP 8'h14
`define SLP_V_PACK_MODE 8'hFE
`define SLP_V_PACK_WFMT 8'h0F
`define SLP_V_PACK_SUBCL 8'h2F
`define SLP_V_FULL_BW 8'h00
`define SLP_V_RANGE_MID 8'h00
`define SLP_V_RANGE_LOW 8'h10
`define SLP_V_RANGE_TOP 8'h30
`define SLP_V_RANGE_MIN 8'h50
`define SLP_BIT_LOCK 7
`define SLP_BIT_LOL 3
`define SLP_BIT_LINK_PD 0
`define SLP_BIT_OFFS_BIN 0
`define SLP_BIT_STARTUP_RST 6
`define SLP_BIT_PLL_CAL_RST 2
`define SLP_BIT_LOL_CLR 3

// ----------------------------------------------------------------
// Link figures
// ----------------------------------------------------------------
`define SLP_PACK_LANES 8'h08
`define SLP_PACK_CONVS 8'h02
`define SLP_PACK_LAST 3'h4
`define SLP_PACK_WORDS 3'h4
`define SLP_NPRIME 16
`define SLP_MAX_MBPS 16'h3E80
`define SLP_LOW_MBPS 16'h186A
`define SLP_INSTR_LAST 5'h0F
`define SLP_DATA_LAST 5'h07

`endif

// ### logic/slp_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Types shared by the link setup block
// ----------------------------------------------------------------
package slp_pkg;
   // Serial control port phases, one-hot.
   typedef enum logic [2:0] {
      SLP_IDLE = 3'b001,
      SLP_INSTR = 3'b010,
      SLP_DATA = 3'b100
   } slp_spi_e;
   // One register byte.
   typedef logic [7:0] slp_byte_t;
endpackage
`default_nettype wire

// ### logic/slp_top.sv
`include "slp_consts.svh"
`default_nettype none

// ----------------------------------------------------------------
// Sample FIFO between the packer and the lane serializer
// ----------------------------------------------------------------
module slp_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 32
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic flush,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   // Storage words; the extra pointer bit tells full from empty.
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_ptr_q;
   logic [AW:0] rd_ptr_q;
   wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
   wire empty = (wr_ptr_q == rd_ptr_q);
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rd_ptr_q[AW-1:0]];
   // Pointers; a flush empties the queue without touching storage.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else if (flush) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
      end else begin
         if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
         if (pop) rd_ptr_q <= rd_ptr_q + 1'b1;
      end
   end

   // Storage has no reset, so it maps onto plain memory.
   always_ff @(posedge clk) begin
      if (push) mem_q[wr_ptr_q[AW-1:0]] <= in_data;
   end
endmodule

// ----------------------------------------------------------------
// Link setup, status and packing
// ----------------------------------------------------------------
module slp_top import slp_pkg::*; #(
   parameter logic [15:0] ADC_MHZ = 16'd3000
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic spi_cs_n,
   input wire logic spi_sclk,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe_n,
   input wire logic power_down_pin,
   input wire logic pll_locked,
   input wire logic adc_valid,
   output logic adc_ready,
   input wire logic [11:0] adc0_sample,
   input wire logic [11:0] adc1_sample,
   output logic lane_valid,
   input wire logic lane_ready,
   output logic [31:0] lane_data,
   output logic lanes_powered_up,
   output logic pack_mode_active,
   output logic [1:0] lane_range_sel,
   output logic lane_range_ok,
   output logic lane_rate_too_high,
   output logic lane_rate_low,
   output logic deemph_enable,
   output logic startup_hold,
   output logic pll_cal_reset
);

   // ----------------------------------------------------------------
   // Serial control port
   // ----------------------------------------------------------------
   slp_spi_e st_q;           // Port phase.
   slp_spi_e st_d;
   logic sclk_q;             // Previous clock level for edge finding.
   logic [4:0] cnt_q;        // Bits seen in this phase.
   logic [15:0] sh_q;        // Incoming shift register.
   logic rw_q;               // High for a read transfer.
   logic [14:0] addr_q;      // Register address of the transfer.
   slp_byte_t out_q;         // Outgoing read byte.
   logic wr_stb_q;           // One-cycle write strobe.
   logic [14:0] wr_addr_q;
   slp_byte_t wr_data_q;
   wire sel = !spi_cs_n;
   wire rise = sel && spi_sclk && !sclk_q;
   wire fall = sel && !spi_sclk && sclk_q;
   wire instr_done = (st_q == SLP_INSTR) && rise && (cnt_q == `SLP_INSTR_LAST);
   wire data_done = (st_q == SLP_DATA) && rise && (cnt_q == `SLP_DATA_LAST);
   wire [14:0] instr_addr = {sh_q[13:0], spi_sdi};
   slp_byte_t rd_data;
   // Phase sequencing; raising chip select abandons any transfer.
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         SLP_IDLE: if (sel) st_d = SLP_INSTR;
         SLP_INSTR: if (!sel) st_d = SLP_IDLE; else if (instr_done) st_d = SLP_DATA;
         SLP_DATA: if (!sel) st_d = SLP_IDLE; else if (data_done) st_d = SLP_INSTR;
         default: st_d = SLP_IDLE;
      endcase
   end

   // Shifting and bit counting, MSB first, sampled on rising edges.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q <= SLP_IDLE;
         sclk_q <= 1'b0;
         cnt_q <= '0;
         sh_q <= '0;
      end else begin
         st_q <= st_d;
         sclk_q <= spi_sclk;
         if (st_d != st_q) cnt_q <= '0;
         else if (rise) cnt_q <= cnt_q + 1'b1;
         if (rise) sh_q <= {sh_q[14:0], spi_sdi};
      end
   end

   // Instruction capture and read byte output; a read byte is loaded
   // as the instruction ends so its first bit is ready before the
   // first data clock, then shifted on each falling edge after that.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rw_q <= 1'b0;
         addr_q <= '0;
         out_q <= '0;
      end else if (instr_done) begin
         rw_q <= sh_q[14];
         addr_q <= instr_addr;
         out_q <= rd_data;
      end else if (fall && st_q == SLP_DATA && cnt_q != '0) begin
         out_q <= {out_q[6:0], 1'b0};
      end
   end

   // Write strobe at the eighth data bit of a write transfer.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         wr_stb_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
      end else begin
         wr_stb_q <= data_done && !rw_q;
         wr_addr_q <= addr_q;
         wr_data_q <= {sh_q[6:0], spi_sdi};
      end
   end

   assign spi_sdo = out_q[7];
   // The output enable is low only while a read byte is driven.
   assign spi_sdo_oe_n = !(sel && st_q == SLP_DATA && rw_q);
   // ----------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------
   slp_byte_t pwr_q, chbw_q, decim_q, fmt_q, lrate_q, lmode_q, lctl_q;
   slp_byte_t wfmt_q, subcl_q, pllcal_q, startup_q, lolclr_q, lanes_q, convs_q;
   slp_byte_t deemph_q [8];  // De-emphasis controls, zero means off.
   logic soft_rst_q;         // Registered soft reset pulse.
   logic dp_rst_q;           // Registered datapath reset pulse.
   // Address decode as named write enables.
   function automatic logic hit(input logic [14:0] a);
      return wr_stb_q && (wr_addr_q == a);
   endfunction
   wire we_soft = hit(`SLP_A_SOFT_RST);
   wire we_dp = hit(`SLP_A_DP_RST);
   wire we_lctl = hit(`SLP_A_LINK_CTL);
   wire we_lolclr = hit(`SLP_A_LOL_CLR);
   function automatic logic in_deemph(input logic [14:0] a);
      return (a >= `SLP_A_DEEMPH_LO) && (a <= `SLP_A_DEEMPH_HI);
   endfunction
   wire we_deemph = wr_stb_q && in_deemph(wr_addr_q);
   wire [2:0] deemph_idx = 3'(wr_addr_q - `SLP_A_DEEMPH_LO);
   // Configuration registers; a soft reset returns them to defaults.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pwr_q <= `SLP_RST_ZERO;
         chbw_q <= `SLP_RST_ZERO;
         decim_q <= `SLP_RST_DECIM;
         fmt_q <= `SLP_RST_ZERO;
         lrate_q <= `SLP_RST_LANE_RATE;
         lmode_q <= `SLP_RST_ZERO;
         lctl_q <= `SLP_RST_LINK_CTL;
         wfmt_q <= `SLP_RST_ZERO;
         subcl_q <= `SLP_RST_ZERO;
         pllcal_q <= `SLP_RST_ZERO;
         startup_q <= `SLP_RST_STARTUP;
         lolclr_q <= `SLP_RST_ZERO;
         lanes_q <= `SLP_RST_LANES;
         convs_q <= `SLP_RST_CONVS;
         for (int i = 0; i < 8; i++) deemph_q[i] <= `SLP_RST_ZERO;
      end else if (soft_rst_q) begin
         pwr_q <= `SLP_RST_ZERO;
         chbw_q <= `SLP_RST_ZERO;
         decim_q <= `SLP_RST_DECIM;
         fmt_q <= `SLP_RST_ZERO;
         lrate_q <= `SLP_RST_LANE_RATE;
         lmode_q <= `SLP_RST_ZERO;
         lctl_q <= `SLP_RST_LINK_CTL;
         wfmt_q <= `SLP_RST_ZERO;
         subcl_q <= `SLP_RST_ZERO;
         pllcal_q <= `SLP_RST_ZERO;
         startup_q <= `SLP_RST_STARTUP;
         lolclr_q <= `SLP_RST_ZERO;
         lanes_q <= `SLP_RST_LANES;
         convs_q <= `SLP_RST_CONVS;
         for (int i = 0; i < 8; i++) deemph_q[i] <= `SLP_RST_ZERO;
      end else begin
         if (hit(`SLP_A_PWR_MODE)) pwr_q <= wr_data_q;
         if (hit(`SLP_A_CHAN_BW)) chbw_q <= wr_data_q;
         if (hit(`SLP_A_DECIM)) decim_q <= wr_data_q;
         if (hit(`SLP_A_OUT_FMT)) fmt_q <= wr_data_q;
         if (hit(`SLP_A_LANE_RATE)) lrate_q <= wr_data_q;
         if (hit(`SLP_A_LINK_MODE)) lmode_q <= wr_data_q;
         if (we_lctl) lctl_q <= wr_data_q;
         if (hit(`SLP_A_WORD_FMT)) wfmt_q <= wr_data_q;
         if (hit(`SLP_A_SUBCLASS)) subcl_q <= wr_data_q;
         if (hit(`SLP_A_PLL_CAL)) pllcal_q <= wr_data_q;
         if (hit(`SLP_A_STARTUP)) startup_q <= wr_data_q;
         if (we_lolclr) lolclr_q <= wr_data_q;
         if (hit(`SLP_A_LANES)) lanes_q <= wr_data_q;
         if (hit(`SLP_A_CONVS)) convs_q <= wr_data_q;
         if (we_deemph) deemph_q[deemph_idx] <= wr_data_q;
      end
   end

   // Reset commands act once and the registers read back as zero.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         soft_rst_q <= 1'b0;
         dp_rst_q <= 1'b0;
      end else begin
         soft_rst_q <= we_soft && (wr_data_q == `SLP_V_SOFT_RST);
         dp_rst_q <= we_dp && (wr_data_q == `SLP_V_DP_RST);
      end
   end

   // ----------------------------------------------------------------
   // PLL lock status and sticky lock-lost flag
   // ----------------------------------------------------------------
   logic lock_q;                 // Lock indication, one cycle old.
   logic pll_lock_lost_sticky_q; // Sticky lock-lost flag.
   logic restart_arm_q;          // Link taken down, waiting for 0x14.
   // The flag is armed from a lock seen, so an unlocked PLL straight
   // out of reset does not raise it.
   wire lock_fell = lock_q && !pll_locked;
   wire restart = we_lctl && restart_arm_q && (wr_data_q == `SLP_V_LINK_UP);
   wire lol_clr = restart || (we_lolclr && wr_data_q[`SLP_BIT_LOL_CLR]);
   // A loss that lands in the clearing cycle still sets the flag.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lock_q <= 1'b0;
         pll_lock_lost_sticky_q <= 1'b0;
         restart_arm_q <= 1'b0;
      end else begin
         lock_q <= pll_locked;
         pll_lock_lost_sticky_q <= lock_fell || (pll_lock_lost_sticky_q && !lol_clr && !soft_rst_q);
         if (we_lctl) restart_arm_q <= (wr_data_q == `SLP_V_LINK_DOWN);
      end
   end

   wire [7:0] pll_stat = (8'(lock_q) << `SLP_BIT_LOCK) | (8'(pll_lock_lost_sticky_q) << `SLP_BIT_LOL);
   // Read multiplexer; unmapped addresses read as zero.
   always_comb begin
      unique case (instr_addr)
         `SLP_A_PWR_MODE: rd_data = pwr_q;
         `SLP_A_CHAN_BW: rd_data = chbw_q;
         `SLP_A_DECIM: rd_data = decim_q;
         `SLP_A_OUT_FMT: rd_data = fmt_q;
         `SLP_A_LANE_RATE: rd_data = lrate_q;
         `SLP_A_PLL_STAT: rd_data = pll_stat;
         `SLP_A_LINK_MODE: rd_data = lmode_q;
         `SLP_A_LINK_CTL: rd_data = lctl_q;
         `SLP_A_WORD_FMT: rd_data = wfmt_q;
         `SLP_A_SUBCLASS: rd_data = subcl_q;
         `SLP_A_PLL_CAL: rd_data = pllcal_q;
         `SLP_A_STARTUP: rd_data = startup_q;
         `SLP_A_LOL_CLR: rd_data = lolclr_q;
         `SLP_A_LANES: rd_data = lanes_q;
         `SLP_A_CONVS: rd_data = convs_q;
         default: rd_data = in_deemph(instr_addr) ? deemph_q[3'(instr_addr - `SLP_A_DEEMPH_LO)] : `SLP_RST_ZERO;
      endcase
   end
   // ----------------------------------------------------------------
   // Link setup decode
   // ----------------------------------------------------------------
   // Packing needs all three link writes and full bandwidth mode.
   assign pack_mode_active = (lmode_q == `SLP_V_PACK_MODE) && (wfmt_q == `SLP_V_PACK_WFMT)
      && (subcl_q == `SLP_V_PACK_SUBCL) && (chbw_q == `SLP_V_FULL_BW);
   // Drivers are up unless a power-down source is active.
   assign lanes_powered_up = !power_down_pin && (pwr_q[1:0] == 2'h0) && !lctl_q[`SLP_BIT_LINK_PD];
   assign startup_hold = startup_q[`SLP_BIT_STARTUP_RST];
   assign pll_cal_reset = pllcal_q[`SLP_BIT_PLL_CAL_RST];
   assign deemph_enable = (deemph_q[0] | deemph_q[1] | deemph_q[2] | deemph_q[3]
      | deemph_q[4] | deemph_q[5] | deemph_q[6] | deemph_q[7]) != `SLP_RST_ZERO;
   // Range select: 0 top, 1 mid, 2 low, 3 minimum band.
   assign lane_range_ok = (lrate_q == `SLP_V_RANGE_TOP) || (lrate_q == `SLP_V_RANGE_MID)
      || (lrate_q == `SLP_V_RANGE_LOW) || (lrate_q == `SLP_V_RANGE_MIN);
   assign lane_range_sel = (lrate_q == `SLP_V_RANGE_MID) ? 2'h1 :
                           (lrate_q == `SLP_V_RANGE_LOW) ? 2'h2 :
                           (lrate_q == `SLP_V_RANGE_MIN) ? 2'h3 : 2'h0;
   // Compares M*N'*10/8*fadc/(dcm*L) against a limit without dividing.
   // A zero ratio or lane count is treated as one.
   function automatic logic rate_above(input logic [7:0] m, input logic [7:0] l,
                                       input logic [7:0] d, input logic [15:0] lim);
      logic [47:0] lhs, rhs;
      lhs = 48'(m) * 48'(ADC_MHZ) * 48'(`SLP_NPRIME * 10 / 8);
      rhs = 48'(lim) * 48'((d == 8'h00) ? 8'h01 : d) * 48'((l == 8'h00) ? 8'h01 : l);
      return lhs > rhs;
   endfunction
   wire [7:0] eff_m = pack_mode_active ? `SLP_PACK_CONVS : convs_q;
   wire [7:0] eff_l = pack_mode_active ? `SLP_PACK_LANES : lanes_q;
   assign lane_rate_too_high = rate_above(eff_m, eff_l, decim_q, `SLP_MAX_MBPS);
   assign lane_rate_low = !rate_above(eff_m, eff_l, decim_q, `SLP_LOW_MBPS);
   // ----------------------------------------------------------------
   // Sample formatting and packing
   // ----------------------------------------------------------------
   logic [47:0] col0_q, col1_q;  // Up to four held samples per converter.
   logic [2:0] col_cnt_q;        // Samples held.
   logic [63:0] frm0_q, frm1_q;  // Frames being sent, first word on top.
   logic [2:0] out_rem_q;        // Words of the frame still to send.
   logic fifo_in_ready;
   // Offset binary flips the sign bit; twos complement passes as is.
   function automatic logic [11:0] fmt_sample(input logic [11:0] s);
      return s ^ {fmt_q[`SLP_BIT_OFFS_BIN], 11'h000};
   endfunction
   wire [11:0] f0 = fmt_sample(adc0_sample);
   wire [11:0] f1 = fmt_sample(adc1_sample);
   wire emit = pack_mode_active && (out_rem_q != 3'h0);
   wire frame_full = col_cnt_q == `SLP_PACK_LAST;
   // A fifth sample waits until the previous frame has left.
   assign adc_ready = pack_mode_active ? !(frame_full && emit) : fifo_in_ready;
   wire take = adc_valid && adc_ready;
   wire close = pack_mode_active && take && frame_full;
   wire pop_word = emit && fifo_in_ready;
   wire fifo_in_valid = pack_mode_active ? emit : adc_valid;
   wire [31:0] plain_word = {{4{f1[11]}}, f1, {4{f0[11]}}, f0};
   wire [31:0] pack_word = {frm1_q[63:48], frm0_q[63:48]};
   wire [31:0] fifo_in_data = pack_mode_active ? pack_word : plain_word;
   // Collect four samples, close the frame with the fifth and zero fill.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         col0_q <= '0;
         col1_q <= '0;
         col_cnt_q <= '0;
      end else if (dp_rst_q || soft_rst_q || !pack_mode_active) begin
         col_cnt_q <= '0;
      end else if (take) begin
         col0_q <= {col0_q[35:0], f0};
         col1_q <= {col1_q[35:0], f1};
         col_cnt_q <= frame_full ? 3'h0 : col_cnt_q + 1'b1;
      end
   end

   // Send a closed frame as four 16-bit words per converter.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         frm0_q <= '0;
         frm1_q <= '0;
         out_rem_q <= '0;
      end else if (dp_rst_q || soft_rst_q) begin
         out_rem_q <= '0;
      end else if (close) begin
         frm0_q <= {col0_q, f0, 4'h0};
         frm1_q <= {col1_q, f1, 4'h0};
         out_rem_q <= `SLP_PACK_WORDS;
      end else if (pop_word) begin
         frm0_q <= {frm0_q[47:0], 16'h0000};
         frm1_q <= {frm1_q[47:0], 16'h0000};
         out_rem_q <= out_rem_q - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Lane buffer
   // ----------------------------------------------------------------
   // Back-pressure from the lanes stalls the packer and the sample input.
   slp_fifo #(.WIDTH(32), .DEPTH(32)) u_fifo (
      .clk(mclk), .nrst(nrst), .flush(dp_rst_q || soft_rst_q), .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready), .in_data(fifo_in_data), .out_valid(lane_valid), .out_ready(lane_ready),
      .out_data(lane_data));
endmodule
`default_nettype wire

// ### test/slp_rx_model.sv
`default_nettype none
// Link receiver stand-in: takes lane words but stalls on a fixed pseudo-random pattern.
module slp_rx_model (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic lane_valid,
   output logic lane_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] lfsr_q;
   // Ready moves on the falling edge so the sampling edge always sees it settled.
   always @(negedge mclk or negedge nrst) begin
      if (!nrst) lfsr_q <= 5'h1F;
      else lfsr_q <= {lfsr_q[3:0], lfsr_q[4] ^ lfsr_q[2]};
   end
   assign lane_ready = lfsr_q[0] | lfsr_q[3];
endmodule
`default_nettype wire

// ### test/slp_top_props.sv
`default_nettype none
// Port-level checks beside the link setup block.
module slp_top_props (
   input wire logic mclk, nrst, spi_cs_n, spi_sdo_oe_n, power_down_pin, lane_valid, lane_ready, adc_ready,
   input wire logic [31:0] lane_data,
   input wire logic lanes_powered_up, lane_range_ok, lane_rate_too_high, lane_rate_low, deemph_enable,
   input wire logic [1:0] lane_range_sel
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   // A word offered but not taken must wait unchanged.
   sequence s_stall;
      lane_valid && !lane_ready;
   endsequence
   AST_LANE_HOLD: assert property (s_stall |=> lane_valid && $stable(lane_data)) else $error("word moved");
   AST_PWR_UP: assert property ($rose(nrst) && !power_down_pin |-> lanes_powered_up) else $error("lanes off");
   AST_DEEMPH_OFF: assert property ($rose(nrst) |-> !deemph_enable) else $error("deemph on");
   AST_RANGE_RST: assert property ($rose(nrst) |-> lane_range_ok && lane_range_sel == 2'h0) else $error("range");
   AST_RANGE_BAD: assert property (!lane_range_ok |-> lane_range_sel == 2'h0) else $error("bad range sel");
   AST_RATE_FLAGS: assert property (lane_rate_too_high |-> !lane_rate_low) else $error("rate flags");
   AST_OE_IDLE: assert property (spi_cs_n |-> spi_sdo_oe_n) else $error("sdo driven");
   AST_EMPTY_RST: assert property ($rose(nrst) |-> !lane_valid && adc_ready) else $error("not empty");
endmodule
bind slp_top slp_top_props chk_u (.mclk(mclk), .nrst(nrst), .spi_cs_n(spi_cs_n), .spi_sdo_oe_n(spi_sdo_oe_n),
   .power_down_pin(power_down_pin), .lane_valid(lane_valid), .lane_ready(lane_ready), .adc_ready(adc_ready),
   .lane_data(lane_data), .lanes_powered_up(lanes_powered_up), .lane_range_ok(lane_range_ok),
   .lane_rate_too_high(lane_rate_too_high), .lane_rate_low(lane_rate_low), .deemph_enable(deemph_enable),
   .lane_range_sel(lane_range_sel));
`default_nettype wire

// ### test/testbench.sv
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk, nrst, cs_n, sclk, sdi, pdn, lock, av, ar, lv, lr, pwr, pk, rok, hi, lo, de, sdo, oe_n;
   logic [11:0] s0, s1;
   logic [11:0] a[5], b[5];
   logic [31:0] ld;
   logic [1:0] rsel;
   logic sth, pcr;
   logic [7:0] r;
   logic [63:0] f0, f1;
   logic [31:0] exp_q[$];
   logic [7:0] rv[5] = '{8'h00, 8'h10, 8'h50, 8'h20, 8'h30};
   logic [2:0] rx[5] = '{3'h5, 3'h6, 3'h7, 3'h0, 3'h4};
   logic [14:0] ia[7] = '{15'h1228, 15'h1228, 15'h1222, 15'h1222, 15'h1222, 15'h1262, 15'h1262};
   logic [7:0] iv[7] = '{8'h4F, 8'h0F, 8'h00, 8'h04, 8'h00, 8'h08, 8'h00};
   logic [1:0] ix[7] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};
   int n_errors = 0, samples_checked = 0, cyc = 0, seed;
   slp_top dut_u (.mclk(mclk), .nrst(nrst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_sdi(sdi), .spi_sdo(sdo),
      .spi_sdo_oe_n(oe_n), .power_down_pin(pdn), .pll_locked(lock), .adc_valid(av), .adc_ready(ar),
      .adc0_sample(s0), .adc1_sample(s1), .lane_valid(lv), .lane_ready(lr), .lane_data(ld),
      .lanes_powered_up(pwr), .pack_mode_active(pk), .lane_range_sel(rsel), .lane_range_ok(rok),
      .lane_rate_too_high(hi), .lane_rate_low(lo), .deemph_enable(de), .startup_hold(sth), .pll_cal_reset(pcr));
   slp_rx_model rx_u (.mclk(mclk), .nrst(nrst), .lane_valid(lv), .lane_ready(lr));
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      samples_checked++;
      if (got !== want) begin
         n_errors++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic conclude();
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // One 16+8 bit frame; each serial clock phase lasts two mclk, twice the one-mclk minimum the edge finder needs.
   task automatic spi(input logic [15:0] ins, input logic [7:0] wd);
      logic [23:0] sh;
      sh = {ins, wd};
      cs_n = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = sh[i];
         repeat (2) @(negedge mclk);
         if (i < 8) r[i] = sdo;
         sclk = 1'b1;
         repeat (2) @(negedge mclk);
      end
      sclk = 1'b0;
      cs_n = 1'b1;
      repeat (4) @(negedge mclk);
   endtask
   task automatic wr(input logic [14:0] ad, input logic [7:0] d);
      spi({1'b0, ad}, d);
   endtask
   task automatic rd_chk(input logic [14:0] ad, input logic [7:0] e);
      spi({1'b1, ad}, 8'h00);
      chk({24'h0, r}, {24'h0, e});
   endtask
   // Valid stays up across back-to-back pairs; the edge between two falling edges takes the pair.
   task automatic send(input logic [11:0] x, input logic [11:0] y);
      av = 1'b1;
      s0 = x;
      s1 = y;
      for (int k = 0; k < 200 && !ar; k++) @(negedge mclk);
      @(negedge mclk);
   endtask
   task automatic drain();
      av = 1'b0;
      for (int k = 0; k < 500 && exp_q.size() != 0; k++) @(negedge mclk);
   endtask
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Watches the lane side and pairs each word taken with the oldest expected one.
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end else if (nrst && lv && lr) chk(ld, exp_q.size() != 0 ? exp_q.pop_front() : 32'hX);
   end
   initial begin
      seed = 32'h2C95;
      {nrst, cs_n, sclk, sdi, pdn, lock, av} = 7'b0100000;
      s0 = 12'h000;
      s1 = 12'h000;
      repeat (3) @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      chk(32'({pwr, hi, lo, de, sth, pcr}), 32'h20);
      pdn = 1'b1;
      @(negedge mclk);
      chk(32'(pwr), 32'h0);
      pdn = 1'b0;
      rd_chk(15'h056E, 8'h30);
      rd_chk(15'h0561, 8'h00);
      rd_chk(15'h056F, 8'h00);
      rd_chk(15'h0300, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(15'h056E, rv[k]);
         chk(32'({rok, rsel}), 32'(rx[k]));
      end
      wr(15'h0201, 8'h03);
      wr(15'h056E, 8'h10);
      chk(32'({hi, lo, rok, rsel}), 32'hE);
      wr(15'h05C7, 8'h01);
      chk(32'(de), 32'h1);
      lock = 1'b1;
      repeat (4) @(negedge mclk);
      rd_chk(15'h056F, 8'h80);
      lock = 1'b0;
      repeat (4) @(negedge mclk);
      rd_chk(15'h056F, 8'h08);
      wr(15'h0571, 8'h15);
      chk(32'(pwr), 32'h0);
      wr(15'h0571, 8'h14);
      rd_chk(15'h056F, 8'h00);
      for (int k = 0; k < 12; k++) begin
         a[0] = 12'($random(seed));
         b[0] = 12'($random(seed));
         exp_q.push_back({{4{b[0][11]}}, b[0], {4{a[0][11]}}, a[0]});
         send(a[0], b[0]);
      end
      drain();
      wr(15'h0571, 8'h15);
      wr(15'h0570, 8'hFE);
      wr(15'h058B, 8'h0F);
      wr(15'h058F, 8'h2F);
      wr(15'h0571, 8'h14);
      chk(32'(pk), 32'h1);
      wr(15'h0200, 8'h01);
      chk(32'(pk), 32'h0);
      wr(15'h0200, 8'h00);
      for (int k = 0; k < 5; k++) begin
         a[k] = 12'($random(seed));
         b[k] = 12'($random(seed));
      end
      f0 = {a[0], a[1], a[2], a[3], a[4], 4'h0};
      f1 = {b[0], b[1], b[2], b[3], b[4], 4'h0};
      for (int k = 0; k < 4; k++) exp_q.push_back({f1[63-16*k -: 16], f0[63-16*k -: 16]});
      for (int k = 0; k < 5; k++) send(a[k], b[k]);
      drain();
      chk(32'(exp_q.size()), 32'h0);
      wr(15'h0000, 8'h81);
      chk(32'({pk, de}), 32'h0);
      rd_chk(15'h0000, 8'h00);
      wr(15'h0001, 8'h02);
      lock = 1'b1;
      repeat (4) @(negedge mclk);
      lock = 1'b0;
      for (int k = 0; k < 7; k++) begin
         wr(ia[k], iv[k]);
         chk(32'({sth, pcr}), 32'(ix[k]));
      end
      rd_chk(15'h056F, 8'h00);
      conclude();
   end
endmodule
`default_nettype wire
